// [crlp_ctrl.sv]
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "crlp_consts.svh"

module crlp_ctrl (
  // Clock, clock enable and reset
  input wire logic i_sys_clk,
  input wire logic i_clk_en,
  input wire logic i_resetn,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Oscillators and supply
  input wire logic i_ext_clk_activity,
  input wire logic i_pll_clk_activity,
  input wire logic i_supply_below_por,
  input wire logic i_supply_below_threshold,
  input wire logic [1:0] i_boot_pins,
  // Core low-power request
  input wire logic i_sleep_req,
  input wire logic i_deep_sleep,
  input wire logic i_standby_sel,
  input wire logic i_wake_event,
  // Wakeup sources
  input wire logic [15:0] i_event_lines,
  input wire logic i_rtc_alarm,
  input wire logic i_external_reset_pin_n,
  input wire logic i_watchdog_reset,
  input wire logic i_wakeup_pin,
  // Clock and power controls
  output logic [1:0] o_sysclk_sel,
  output logic o_cpu_clk_en,
  output logic o_core_clk_en,
  output logic o_rc_en,
  output logic o_ext_osc_en,
  output logic o_pll_en,
  output logic o_ahb_tick,
  output logic o_fast_tick,
  output logic o_slow_tick,
  output logic [1:0] o_regulator_mode,
  output logic o_regulator_en,
  output logic o_regulator_hiz,
  output logic o_core_resetn,
  output logic o_supply_det_en,
  output logic o_backup_keep_on,
  output logic [1:0] o_boot_src,
  // Interrupts
  output logic o_clk_fail_irq,
  output logic o_supply_irq
);

  crlp_pkg::crlp_mode_type mode, next_mode;
  logic [5:0] ctrl, next_ctrl;
  logic [1:0] src, next_src;
  logic ext_fail_flag, next_ext_fail_flag;
  logic pll_fail_flag, next_pll_fail_flag;
  logic [11:0] presc, next_presc;
  logic [2:0] sup_ctrl, next_sup_ctrl;
  logic sup_flag, next_sup_flag;
  logic sup_prev, next_sup_prev;
  logic stop_lp, next_stop_lp;
  logic [1:0] boot, next_boot;
  logic boot_taken, next_boot_taken;
  logic wakeup_pin_prev, next_wakeup_pin_prev;
  logic ext_fail, pll_fail;
  logic sup_fall, sup_rise;
  logic standby_exit, run_clocks;
  logic [7:0] wr_addr, next_wr_addr;
  logic wr_pend, next_wr_pend;
  logic [31:0] next_hrdata;
  logic wr_en;

  // Clock watchdogs for the external oscillator and the PLL input.
  crlp_activity_monitor u_ext_mon (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_enable(src == 2'(crlp_pkg::CRLP_SRC_EXT) && o_ext_osc_en),
    .i_activity(i_ext_clk_activity),
    .o_fail(ext_fail)
  );

  crlp_activity_monitor u_pll_mon (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_enable(o_pll_en),
    .i_activity(i_pll_clk_activity),
    .o_fail(pll_fail)
  );

  assign run_clocks = (mode == crlp_pkg::CRLP_RUN) ||
                      (mode == crlp_pkg::CRLP_SLEEP);

  // Bus domain prescalers; they halt with the core clocks in Stop.
  crlp_prescaler u_ahb_div (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_run(run_clocks),
    .i_div(presc[`CRLP_PRESC_AHB_LSB +: 4]),
    .o_tick(o_ahb_tick)
  );

  crlp_prescaler u_fast_div (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_run(run_clocks),
    .i_div(presc[`CRLP_PRESC_FAST_LSB +: 4]),
    .o_tick(o_fast_tick)
  );

  crlp_prescaler u_slow_div (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_run(run_clocks),
    .i_div(presc[`CRLP_PRESC_SLOW_LSB +: 4]),
    .o_tick(o_slow_tick)
  );

  assign sup_fall = sup_ctrl[`CRLP_SUP_EN] && i_supply_below_threshold &&
                    !sup_prev;
  assign sup_rise = sup_ctrl[`CRLP_SUP_EN] && !i_supply_below_threshold &&
                    sup_prev;
  assign standby_exit = !i_external_reset_pin_n || i_watchdog_reset ||
                        (i_wakeup_pin && !wakeup_pin_prev) || i_rtc_alarm;
  assign wr_en = wr_pend && i_hready;

  // Registers, clocks and low-power sequencing.
  always_comb begin
    next_mode = mode;
    next_ctrl = ctrl;
    next_src = src;
    next_ext_fail_flag = ext_fail_flag;
    next_pll_fail_flag = pll_fail_flag;
    next_presc = presc;
    next_sup_ctrl = sup_ctrl;
    next_sup_flag = sup_flag;
    next_sup_prev = sup_ctrl[`CRLP_SUP_EN] && i_supply_below_threshold;
    next_stop_lp = stop_lp;
    next_boot = boot;
    next_boot_taken = 1'b1;
    next_wakeup_pin_prev = i_wakeup_pin;
    if (!boot_taken) begin
      if (!i_boot_pins[0]) begin
        next_boot = 2'(crlp_pkg::CRLP_BOOT_FLASH);
      end else if (!i_boot_pins[1]) begin
        next_boot = 2'(crlp_pkg::CRLP_BOOT_SYSMEM);
      end else begin
        next_boot = 2'(crlp_pkg::CRLP_BOOT_SRAM);
      end
    end
    if (wr_en) begin
      case (wr_addr)
        `CRLP_ADDR_CLK_CTRL: begin
          next_ctrl = i_hwdata[5:0];
        end
        `CRLP_ADDR_CLK_STAT: begin
          if (i_hwdata[`CRLP_STAT_EXT_FAIL]) begin
            next_ext_fail_flag = 1'b0;
          end
          if (i_hwdata[`CRLP_STAT_PLL_FAIL]) begin
            next_pll_fail_flag = 1'b0;
          end
        end
        `CRLP_ADDR_PRESC: begin
          next_presc = i_hwdata[11:0];
        end
        `CRLP_ADDR_SUPPLY: begin
          next_sup_ctrl = i_hwdata[2:0];
          if (i_hwdata[`CRLP_SUP_FLAG]) begin
            next_sup_flag = 1'b0;
          end
        end
        `CRLP_ADDR_PWR: begin
          next_stop_lp = i_hwdata[`CRLP_PWR_STOP_LP];
        end
        default: begin
        end
      endcase
    end
    // Hardware set wins over a same-cycle software clear.
    if ((sup_fall && sup_ctrl[`CRLP_SUP_FALL_IE]) ||
        (sup_rise && sup_ctrl[`CRLP_SUP_RISE_IE])) begin
      next_sup_flag = 1'b1;
    end
    if (ext_fail) begin
      next_ext_fail_flag = 1'b1;
    end
    if (pll_fail) begin
      next_pll_fail_flag = 1'b1;
    end
    // Source selection follows software unless a failure overrides it.
    case (next_ctrl[`CRLP_CTRL_SEL_LSB +: 2])
      2'(crlp_pkg::CRLP_SRC_EXT): begin
        next_src = next_ctrl[`CRLP_CTRL_EXT_EN] ?
                   2'(crlp_pkg::CRLP_SRC_EXT) : 2'(crlp_pkg::CRLP_SRC_RC);
      end
      2'(crlp_pkg::CRLP_SRC_PLL): begin
        next_src = next_ctrl[`CRLP_CTRL_PLL_EN] ?
                   2'(crlp_pkg::CRLP_SRC_PLL) : 2'(crlp_pkg::CRLP_SRC_RC);
      end
      default: begin
        next_src = 2'(crlp_pkg::CRLP_SRC_RC);
      end
    endcase
    if ((ext_fail && src == 2'(crlp_pkg::CRLP_SRC_EXT)) ||
        (pll_fail && src == 2'(crlp_pkg::CRLP_SRC_PLL))) begin
      next_ctrl[`CRLP_CTRL_SEL_LSB +: 2] = 2'(crlp_pkg::CRLP_SRC_RC);
      next_src = 2'(crlp_pkg::CRLP_SRC_RC);
    end
    case (mode)
      crlp_pkg::CRLP_RUN: begin
        if (i_sleep_req && !i_deep_sleep) begin
          next_mode = crlp_pkg::CRLP_SLEEP;
        end else if (i_sleep_req && !i_standby_sel) begin
          next_mode = crlp_pkg::CRLP_STOP;
        end else if (i_sleep_req) begin
          next_mode = crlp_pkg::CRLP_STANDBY;
        end
      end
      crlp_pkg::CRLP_SLEEP: begin
        if (i_wake_event) begin
          next_mode = crlp_pkg::CRLP_RUN;
        end
      end
      crlp_pkg::CRLP_STOP: begin
        if ((|i_event_lines) || sup_fall || sup_rise || i_rtc_alarm) begin
          next_mode = crlp_pkg::CRLP_RUN;
          next_ctrl[`CRLP_CTRL_SEL_LSB +: 2] =
            2'(crlp_pkg::CRLP_SRC_RC);
          next_src = 2'(crlp_pkg::CRLP_SRC_RC);
        end
      end
      crlp_pkg::CRLP_STANDBY: begin
        if (standby_exit) begin
          next_mode = crlp_pkg::CRLP_RUN;
        end
      end
      default: begin
        next_mode = crlp_pkg::CRLP_RUN;
      end
    endcase
    // Standby content loss and the supply hold both restart the block.
    if ((mode == crlp_pkg::CRLP_STANDBY) || i_supply_below_por) begin
      next_ctrl = `CRLP_CTRL_RESET;
      next_src = 2'(crlp_pkg::CRLP_SRC_RC);
      next_ext_fail_flag = 1'b0;
      next_pll_fail_flag = 1'b0;
      next_presc = `CRLP_PRESC_RESET;
      next_sup_ctrl = `CRLP_SUP_RESET;
      next_sup_flag = 1'b0;
      next_sup_prev = 1'b0;
      next_stop_lp = `CRLP_PWR_RESET;
      next_boot_taken = 1'b0;
    end
    if (i_supply_below_por) begin
      next_mode = crlp_pkg::CRLP_RUN;
    end
  end

  // AHB-Lite slave: zero wait states, read data from post-write values.
  always_comb begin
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_hrdata = 32'h0000_0000;
    if (i_hready && i_hsel && i_htrans[1]) begin
      next_wr_pend = i_hwrite;
      next_wr_addr = i_haddr[7:0];
      if (!i_hwrite) begin
        case (i_haddr[7:0])
          `CRLP_ADDR_CLK_CTRL: begin
            next_hrdata[5:0] = next_ctrl;
          end
          `CRLP_ADDR_CLK_STAT: begin
            next_hrdata[`CRLP_STAT_SRC_LSB +: 2] = next_src;
            next_hrdata[`CRLP_STAT_EXT_FAIL] = next_ext_fail_flag;
            next_hrdata[`CRLP_STAT_PLL_FAIL] = next_pll_fail_flag;
            next_hrdata[`CRLP_STAT_BOOT_LSB +: 2] = next_boot;
          end
          `CRLP_ADDR_PRESC: begin
            next_hrdata[11:0] = next_presc;
          end
          `CRLP_ADDR_SUPPLY: begin
            next_hrdata[2:0] = next_sup_ctrl;
            next_hrdata[`CRLP_SUP_FLAG] = next_sup_flag;
            next_hrdata[`CRLP_SUP_LEVEL] = i_supply_below_threshold;
          end
          `CRLP_ADDR_PWR: begin
            next_hrdata[`CRLP_PWR_STOP_LP] = next_stop_lp;
            next_hrdata[`CRLP_PWR_MODE_LSB +: 2] = 2'(next_mode);
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode <= crlp_pkg::CRLP_RUN;
      ctrl <= `CRLP_CTRL_RESET;
      src <= 2'(crlp_pkg::CRLP_SRC_RC);
      ext_fail_flag <= 1'b0;
      pll_fail_flag <= 1'b0;
      presc <= `CRLP_PRESC_RESET;
      sup_ctrl <= `CRLP_SUP_RESET;
      sup_flag <= 1'b0;
      sup_prev <= 1'b0;
      stop_lp <= `CRLP_PWR_RESET;
      boot <= 2'(crlp_pkg::CRLP_BOOT_FLASH);
      boot_taken <= 1'b0;
      wakeup_pin_prev <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      o_hrdata <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_sysclk_sel <= 2'(crlp_pkg::CRLP_SRC_RC);
      o_cpu_clk_en <= 1'b1;
      o_core_clk_en <= 1'b1;
      o_rc_en <= 1'b1;
      o_ext_osc_en <= 1'b0;
      o_pll_en <= 1'b0;
      o_regulator_mode <= 2'(crlp_pkg::CRLP_REG_MAIN);
      o_regulator_en <= 1'b1;
      o_regulator_hiz <= 1'b0;
      o_core_resetn <= 1'b0;
      o_supply_det_en <= 1'b0;
      o_backup_keep_on <= 1'b1;
      o_boot_src <= 2'(crlp_pkg::CRLP_BOOT_FLASH);
      o_clk_fail_irq <= 1'b0;
      o_supply_irq <= 1'b0;
    end else if (i_clk_en) begin
      mode <= next_mode;
      ctrl <= next_ctrl;
      src <= next_src;
      ext_fail_flag <= next_ext_fail_flag;
      pll_fail_flag <= next_pll_fail_flag;
      presc <= next_presc;
      sup_ctrl <= next_sup_ctrl;
      sup_flag <= next_sup_flag;
      sup_prev <= next_sup_prev;
      stop_lp <= next_stop_lp;
      boot <= next_boot;
      boot_taken <= next_boot_taken;
      wakeup_pin_prev <= next_wakeup_pin_prev;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      o_hrdata <= next_hrdata;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_sysclk_sel <= next_src;
      o_cpu_clk_en <= (next_mode == crlp_pkg::CRLP_RUN);
      o_core_clk_en <= (next_mode == crlp_pkg::CRLP_RUN) ||
                       (next_mode == crlp_pkg::CRLP_SLEEP);
      o_rc_en <= (next_mode == crlp_pkg::CRLP_RUN) ||
                 (next_mode == crlp_pkg::CRLP_SLEEP);
      o_ext_osc_en <= next_ctrl[`CRLP_CTRL_EXT_EN] &&
                      ((next_mode == crlp_pkg::CRLP_RUN) ||
                       (next_mode == crlp_pkg::CRLP_SLEEP));
      o_pll_en <= next_ctrl[`CRLP_CTRL_PLL_EN] &&
                  ((next_mode == crlp_pkg::CRLP_RUN) ||
                   (next_mode == crlp_pkg::CRLP_SLEEP));
      case (next_mode)
        crlp_pkg::CRLP_STOP: begin
          o_regulator_mode <= next_stop_lp ? 2'(crlp_pkg::CRLP_REG_LOWPWR) :
                              2'(crlp_pkg::CRLP_REG_MAIN);
        end
        crlp_pkg::CRLP_STANDBY: begin
          o_regulator_mode <= 2'(crlp_pkg::CRLP_REG_OFF);
        end
        default: begin
          o_regulator_mode <= 2'(crlp_pkg::CRLP_REG_MAIN);
        end
      endcase
      o_regulator_en <= (next_mode != crlp_pkg::CRLP_STANDBY);
      o_regulator_hiz <= (next_mode == crlp_pkg::CRLP_STANDBY);
      o_core_resetn <= !i_supply_below_por &&
                       (next_mode != crlp_pkg::CRLP_STANDBY);
      o_supply_det_en <= next_sup_ctrl[`CRLP_SUP_EN];
      o_backup_keep_on <= 1'b1;
      o_boot_src <= next_boot;
      o_clk_fail_irq <= (next_ext_fail_flag &&
                         next_ctrl[`CRLP_CTRL_EXT_IE]) ||
                        (next_pll_fail_flag &&
                         next_ctrl[`CRLP_CTRL_PLL_IE]);
      o_supply_irq <= next_sup_flag;
    end
  end

endmodule // crlp_ctrl

// [crlp_consts.svh]
`ifndef CRLP_CONSTS_SVH
`define CRLP_CONSTS_SVH

// Byte offsets on the low address byte.
`define CRLP_ADDR_CLK_CTRL 8'h00
`define CRLP_ADDR_CLK_STAT 8'h04
`define CRLP_ADDR_PRESC 8'h08
`define CRLP_ADDR_SUPPLY 8'h0c
`define CRLP_ADDR_PWR 8'h10

// Clock control fields.
`define CRLP_CTRL_SEL_LSB 0
`define CRLP_CTRL_EXT_EN 2
`define CRLP_CTRL_PLL_EN 3
`define CRLP_CTRL_EXT_IE 4
`define CRLP_CTRL_PLL_IE 5
`define CRLP_CTRL_RESET 6'h00

// Clock status fields.
`define CRLP_STAT_SRC_LSB 0
`define CRLP_STAT_EXT_FAIL 2
`define CRLP_STAT_PLL_FAIL 3
`define CRLP_STAT_BOOT_LSB 4

// Prescaler fields, each a divide-by-(n+1) value.
`define CRLP_PRESC_AHB_LSB 0
`define CRLP_PRESC_FAST_LSB 4
`define CRLP_PRESC_SLOW_LSB 8
`define CRLP_PRESC_RESET 12'h000

// Supply threshold detector fields.
`define CRLP_SUP_EN 0
`define CRLP_SUP_FALL_IE 1
`define CRLP_SUP_RISE_IE 2
`define CRLP_SUP_FLAG 8
`define CRLP_SUP_LEVEL 9
`define CRLP_SUP_RESET 3'h0

// Power control fields.
`define CRLP_PWR_STOP_LP 0
`define CRLP_PWR_MODE_LSB 4
`define CRLP_PWR_RESET 1'h0

// Timing.
`define CRLP_MON_LIMIT 20
`define CRLP_MON_CNT_W 5

`endif

// [crlp_pkg.sv]
package crlp_pkg;

  typedef enum logic [1:0] {
    CRLP_RUN,
    CRLP_SLEEP,
    CRLP_STOP,
    CRLP_STANDBY
  } crlp_mode_type;

  typedef enum logic [1:0] {
    CRLP_SRC_RC,
    CRLP_SRC_EXT,
    CRLP_SRC_PLL
  } crlp_src_type;

  typedef enum logic [1:0] {
    CRLP_REG_MAIN,
    CRLP_REG_LOWPWR,
    CRLP_REG_OFF
  } crlp_reg_type;

  typedef enum logic [1:0] {
    CRLP_BOOT_FLASH,
    CRLP_BOOT_SYSMEM,
    CRLP_BOOT_SRAM
  } crlp_boot_type;

endpackage

// [crlp_activity_monitor.sv]
`timescale 1ns/100ps
`include "crlp_consts.svh"

// Flags a clock failed when its toggle stops.
module crlp_activity_monitor (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // Watch control
  input wire logic i_enable,
  input wire logic i_activity,
  // Failure pulse
  output logic o_fail
);

  logic prev, next_prev, next_fail;
  logic [`CRLP_MON_CNT_W-1:0] cnt, next_cnt;

  always_comb begin
    next_prev = i_activity;
    next_cnt = cnt;
    next_fail = 1'b0;
    if (!i_enable || (i_activity != prev)) begin
      next_cnt = '0;
    end else if (cnt == `CRLP_MON_CNT_W'(`CRLP_MON_LIMIT - 1)) begin
      next_cnt = `CRLP_MON_CNT_W'(`CRLP_MON_LIMIT);
      next_fail = 1'b1;
    end else if (cnt != `CRLP_MON_CNT_W'(`CRLP_MON_LIMIT)) begin
      next_cnt = cnt + `CRLP_MON_CNT_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev <= 1'b0;
      cnt <= '0;
      o_fail <= 1'b0;
    end else if (i_clk_en) begin
      prev <= next_prev;
      cnt <= next_cnt;
      o_fail <= next_fail;
    end
  end

endmodule // crlp_activity_monitor

// [crlp_prescaler.sv]
`timescale 1ns/100ps

// Emits a one-cycle tick every (i_div + 1) cycles.
module crlp_prescaler (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // Division
  input wire logic i_run,
  input wire logic [3:0] i_div,
  // Domain clock enable
  output logic o_tick
);

  logic [3:0] cnt, next_cnt;
  logic next_tick;

  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!i_run) begin
      next_cnt = 4'h0;
    end else if (cnt >= i_div) begin
      next_cnt = 4'h0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 4'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 4'h0;
      o_tick <= 1'b0;
    end else if (i_clk_en) begin
      cnt <= next_cnt;
      o_tick <= next_tick;
    end
  end

endmodule // crlp_prescaler

// [crlp_osc_model.sv]
`timescale 1ns/100ps

// Stands in for the external and PLL oscillators.
module crlp_osc_model (
  // Clock
  input wire logic i_sys_clk,
  // Enables and commanded failures
  input wire logic i_ext_on,
  input wire logic i_pll_on,
  input wire logic i_ext_dead,
  input wire logic i_pll_dead,
  // Activity toggles
  output logic o_ext_act,
  output logic o_pll_act
);
  initial begin
    o_ext_act = 1'b0;
    o_pll_act = 1'b0;
  end

  // A disabled or failed oscillator leaves its toggle frozen.
  always @(posedge i_sys_clk) begin
    if (i_ext_on && !i_ext_dead) begin
      o_ext_act <= !o_ext_act;
    end
    if (i_pll_on && !i_pll_dead) begin
      o_pll_act <= !o_pll_act;
    end
  end
endmodule // crlp_osc_model

// [crlp_ctrl_sva.sv]
`timescale 1ns/100ps

module crlp_ctrl_sva (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // Inputs
  input wire logic i_supply_below_por,
  input wire logic i_ext_clk_activity,
  input wire logic i_sleep_req,
  input wire logic i_deep_sleep,
  input wire logic i_standby_sel,
  input wire logic i_wake_event,
  input wire logic [15:0] i_event_lines,
  input wire logic i_rtc_alarm,
  input wire logic i_wakeup_pin,
  // Outputs
  input wire logic [1:0] o_sysclk_sel,
  input wire logic o_cpu_clk_en,
  input wire logic o_core_clk_en,
  input wire logic o_rc_en,
  input wire logic o_ext_osc_en,
  input wire logic o_pll_en,
  input wire logic [1:0] o_regulator_mode,
  input wire logic o_regulator_en,
  input wire logic o_regulator_hiz,
  input wire logic o_core_resetn
);
  logic [5:0] idle_cnt, next_idle_cnt;
  logic last_act, next_last_act, ok;

  assign ok = i_clk_en && !i_supply_below_por;

  // Counts idle cycles of a running external clock.
  always_comb begin
    next_last_act = i_ext_clk_activity;
    next_idle_cnt = 6'h00;
    if (o_sysclk_sel == 2'h1 && o_ext_osc_en && o_core_clk_en &&
        i_ext_clk_activity == last_act && idle_cnt != 6'h3f) begin
      next_idle_cnt = idle_cnt + 6'h01;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      idle_cnt <= 6'h00;
      last_act <= 1'b0;
    end else begin
      idle_cnt <= next_idle_cnt;
      last_act <= next_last_act;
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  a_por_restart: assert property (i_supply_below_por |=>
    !o_core_resetn && o_sysclk_sel == 2'h0 && o_regulator_en)
    else $error("restart wrong");
  a_ext_fallback: assert property (o_sysclk_sel == 2'h1 |->
    idle_cnt <= 6'd24) else $error("dead clock kept");
  a_reg_modes: assert property ((o_regulator_mode == 2'h2) ==
    !o_regulator_en && o_regulator_hiz == !o_regulator_en)
    else $error("regulator mismatch");
  a_stop_gates: assert property (!o_core_clk_en |-> !o_cpu_clk_en &&
    !o_rc_en && !o_ext_osc_en && !o_pll_en)
    else $error("source left on");
  a_sleep_entry: assert property (o_cpu_clk_en && ok && i_sleep_req &&
    !i_deep_sleep && !i_wake_event |=> !o_cpu_clk_en && o_core_clk_en)
    else $error("sleep entry wrong");
  a_sleep_wake: assert property (!o_cpu_clk_en && o_core_clk_en && ok &&
    i_wake_event |=> o_cpu_clk_en) else $error("sleep not woken");
  a_stop_entry: assert property (o_cpu_clk_en && ok && i_sleep_req &&
    i_deep_sleep && !i_standby_sel && i_event_lines == 16'h0 &&
    !i_rtc_alarm |=> !o_core_clk_en && o_regulator_en)
    else $error("stop entry wrong");
  a_stop_wake: assert property (!o_core_clk_en && o_regulator_en &&
    ok && (|i_event_lines) |=> o_cpu_clk_en && o_sysclk_sel == 2'h0)
    else $error("stop wake wrong");
  a_standby_entry: assert property (o_cpu_clk_en && ok && i_sleep_req &&
    i_deep_sleep && i_standby_sel && !i_wakeup_pin && !i_rtc_alarm |=>
    !o_regulator_en [*2]) else $error("standby entry wrong");
  a_standby_exit: assert property (!o_regulator_en && ok &&
    $rose(i_wakeup_pin) |-> ##[1:3] o_regulator_en)
    else $error("standby not left");
endmodule // crlp_ctrl_sva

bind crlp_ctrl crlp_ctrl_sva crlp_ctrl_sva_inst (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en),
  .i_supply_below_por(i_supply_below_por),
  .i_ext_clk_activity(i_ext_clk_activity), .i_sleep_req(i_sleep_req),
  .i_deep_sleep(i_deep_sleep), .i_standby_sel(i_standby_sel),
  .i_wake_event(i_wake_event), .i_event_lines(i_event_lines),
  .i_rtc_alarm(i_rtc_alarm), .i_wakeup_pin(i_wakeup_pin),
  .o_sysclk_sel(o_sysclk_sel), .o_cpu_clk_en(o_cpu_clk_en),
  .o_core_clk_en(o_core_clk_en), .o_rc_en(o_rc_en),
  .o_ext_osc_en(o_ext_osc_en), .o_pll_en(o_pll_en),
  .o_regulator_mode(o_regulator_mode), .o_regulator_en(o_regulator_en),
  .o_regulator_hiz(o_regulator_hiz), .o_core_resetn(o_core_resetn)
);

// [crlp_tb.sv]
`timescale 1ns/100ps
`include "crlp_consts.svh"
`define CRLP_CHK(e, a) \
  begin \
    cmp_count++; \
    if ((a) !== (e)) begin \
      errors++; \
      $display("BAD at %0t exp %h got %h", $time, e, a); \
    end \
  end

module tb;
  logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic sreq = 1'b0, deep = 1'b0, sbsel = 1'b0, wake = 1'b0, alarm = 1'b0;
  logic rstpin_n = 1'b1, wdog = 1'b0, wkpin = 1'b0, por = 1'b0, thr = 1'b0;
  logic edead = 1'b0, pdead = 1'b0, snap = 1'b0, rd_ph = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0, boot = 2'h0;
  logic [15:0] ev = 16'h0;
  logic [7:0] gap = 8'h0, tcnt = 8'h0;
  logic [31:0] hrdata, obs, d;
  logic [1:0] sel, rmode;
  logic hrdy, eact, pact, cpu, core, rc, eon, pon, atick, ren, hiz, cres;
  logic cfirq, sirq;
  logic [31:0] exp_q[$], msk_q[$];
  int errors = 0, cmp_count = 0;

  always #50 clk = ~clk;

  assign obs = {10'h0, gap, sel, cpu, core, rc, eon, pon, rmode, ren, hiz,
    cres, cfirq, sirq};

  crlp_osc_model crlp_osc_model_inst (.i_sys_clk(clk), .i_ext_on(eon),
    .i_pll_on(pon), .i_ext_dead(edead), .i_pll_dead(pdead),
    .o_ext_act(eact), .o_pll_act(pact));

  crlp_ctrl crlp_ctrl_inst (.i_sys_clk(clk), .i_clk_en(1'b1),
    .i_resetn(resetn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(),
    .i_ext_clk_activity(eact), .i_pll_clk_activity(pact),
    .i_supply_below_por(por), .i_supply_below_threshold(thr),
    .i_boot_pins(boot), .i_sleep_req(sreq), .i_deep_sleep(deep),
    .i_standby_sel(sbsel), .i_wake_event(wake), .i_event_lines(ev),
    .i_rtc_alarm(alarm), .i_external_reset_pin_n(rstpin_n),
    .i_watchdog_reset(wdog), .i_wakeup_pin(wkpin), .o_sysclk_sel(sel),
    .o_cpu_clk_en(cpu), .o_core_clk_en(core), .o_rc_en(rc),
    .o_ext_osc_en(eon), .o_pll_en(pon), .o_ahb_tick(atick),
    .o_fast_tick(), .o_slow_tick(), .o_regulator_mode(rmode),
    .o_regulator_en(ren), .o_regulator_hiz(hiz), .o_core_resetn(cres),
    .o_supply_det_en(), .o_backup_keep_on(), .o_boot_src(),
    .o_clk_fail_irq(cfirq), .o_supply_irq(sirq));

  // Measures the spacing of bus domain ticks.
  always @(posedge clk) begin
    if (atick === 1'b1) begin
      gap <= tcnt;
      tcnt <= 8'h1;
    end else begin
      tcnt <= tcnt + 8'h1;
    end
  end

  always @(posedge clk) begin : mon
    logic [31:0] e, m;
    if (rd_ph || snap) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CRLP_CHK(e, (rd_ph ? hrdata : obs) & m)
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic addr(input logic [7:0] a, input logic w);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr(a, 1'b1);
    hwdata <= v;
    do @(posedge clk); while (hrdy !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr(a, 1'b0);
    exp_q.push_back(e);
    msk_q.push_back(32'hffffffff);
    rd_ph <= 1'b1;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  task automatic look(input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    snap <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    snap <= 1'b0;
  endtask

  task automatic req(input logic dp, input logic sb);
    @(posedge clk);
    sreq <= 1'b1;
    deep <= dp;
    sbsel <= sb;
    @(posedge clk);
    sreq <= 1'b0;
  endtask

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end

  initial begin
    void'($urandom(7684));
    cyc(10);
    resetn <= 1'b1;
    look(32'h3fff, 32'h0e14);
    rd(`CRLP_ADDR_CLK_CTRL, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'hffffffff);
    for (int i = 2; i >= 0; i--) begin
      por <= 1'b1;
      boot <= (i == 2) ? 2'h3 : i[1:0];
      look(32'h0004, 32'h0);
      por <= 1'b0;
      cyc(3);
      rd(`CRLP_ADDR_CLK_STAT, {26'h0, i[1:0], 4'h0});
    end
    tdone("boot");
    d = $urandom;
    rd(`CRLP_ADDR_PRESC, 32'h0);
    wr(`CRLP_ADDR_PRESC, {20'h0, d[11:0]});
    rd(`CRLP_ADDR_PRESC, {20'h0, d[11:0]});
    cyc(40);
    look(32'h003fc000, {10'h0, {4'h0, d[3:0]} + 8'h1, 14'h0});
    tdone("prescale");
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 32'h15 : (k == 1) ? 32'h05 : 32'h2a;
      wr(`CRLP_ADDR_CLK_CTRL, d);
      cyc(3);
      look(32'h3000, {18'h0, (k == 2) ? 2'h2 : 2'h1, 12'h0});
      if (k == 2) begin
        pdead <= 1'b1;
      end else begin
        edead <= 1'b1;
      end
      cyc(30);
      look(32'h3c02, {18'h0, 4'h3, 8'h0, k != 1, 1'b0});
      rd(`CRLP_ADDR_CLK_STAT, (k == 2) ? 32'h8 : 32'h4);
      wr(`CRLP_ADDR_CLK_CTRL, 32'h0);
      edead <= 1'b0;
      pdead <= 1'b0;
      wr(`CRLP_ADDR_CLK_STAT, 32'hc);
      rd(`CRLP_ADDR_CLK_STAT, 32'h0);
    end
    tdone("clock fail");
    req(1'b0, 1'b0);
    look(32'h3fff, 32'h0614);
    wake <= 1'b1;
    look(32'h3fff, 32'h0e14);
    wake <= 1'b0;
    wr(`CRLP_ADDR_CLK_CTRL, 32'h05);
    for (int k = 0; k < 2; k++) begin
      wr(`CRLP_ADDR_PWR, 32'(k));
      req(1'b1, 1'b0);
      look(32'h3fff, (k == 1) ? 32'h0034 : 32'h1014);
      if (k == 1) begin
        alarm <= 1'b1;
      end else begin
        ev <= 16'h1 << ($urandom % 16);
      end
      look(32'h3c00, 32'h0c00);
      alarm <= 1'b0;
      ev <= 16'h0;
      rd(`CRLP_ADDR_PWR, 32'(k));
    end
    tdone("sleep stop");
    for (int k = 0; k < 4; k++) begin
      wr(`CRLP_ADDR_PWR, 32'h1);
      req(1'b1, 1'b1);
      look(32'h3ffb, 32'h0048);
      case (k)
        0: rstpin_n <= 1'b0;
        1: wdog <= 1'b1;
        2: wkpin <= 1'b1;
        default: alarm <= 1'b1;
      endcase
      cyc(2);
      rstpin_n <= 1'b1;
      wdog <= 1'b0;
      wkpin <= 1'b0;
      alarm <= 1'b0;
      cyc(4);
      rd(`CRLP_ADDR_PWR, 32'h0);
    end
    tdone("standby");
    rd(`CRLP_ADDR_SUPPLY, 32'h0);
    wr(`CRLP_ADDR_SUPPLY, 32'h2);
    thr <= 1'b1;
    cyc(4);
    rd(`CRLP_ADDR_SUPPLY, 32'h202);
    thr <= 1'b0;
    wr(`CRLP_ADDR_SUPPLY, 32'h3);
    thr <= 1'b1;
    cyc(4);
    look(32'h1, 32'h1);
    rd(`CRLP_ADDR_SUPPLY, 32'h303);
    wr(`CRLP_ADDR_SUPPLY, 32'h105);
    thr <= 1'b0;
    cyc(4);
    rd(`CRLP_ADDR_SUPPLY, 32'h105);
    tdone("supply");
    final_report();
  end
endmodule // tb
